// *** hdl/ppfm_pkg.sv ***
// Package for the port pin function multiplexer: register map, field
// positions, pin indices and carrier types.
// Assumes byte-wide registers on a plain strobe port, 9-bit byte address.
package ppfm_pkg;

  // Ports 2..6 are held as entries 0..4
  localparam int NPORT = 5;
  localparam int PW    = 8;
  localparam int AW    = 9;
  localparam int P2    = 0;
  localparam int P3    = 1;
  localparam int P4    = 2;
  localparam int P5    = 3;
  localparam int P6    = 4;

  typedef logic [PW-1:0] ppfm_byte_t;
  typedef logic [AW-1:0] ppfm_addr_t;

  // Register byte addresses, one entry per port
  localparam ppfm_addr_t ADR_IN  [NPORT] = '{9'h028, 9'h018, 9'h01C, 9'h030, 9'h034};
  localparam ppfm_addr_t ADR_OUT [NPORT] = '{9'h029, 9'h019, 9'h01D, 9'h031, 9'h035};
  localparam ppfm_addr_t ADR_DIR [NPORT] = '{9'h02A, 9'h01A, 9'h01E, 9'h032, 9'h036};
  localparam ppfm_addr_t ADR_SEL [NPORT] = '{9'h02E, 9'h01B, 9'h01F, 9'h033, 9'h037};
  localparam ppfm_addr_t ADR_SEGEN = 9'h0A8;
  localparam ppfm_byte_t RST_BYTE  = 8'h00;

  // Segment group enable bits inside the segment enable register
  localparam int SG0  = 0;
  localparam int SG4  = 1;
  localparam int SG8  = 2;
  localparam int SG12 = 3;
  localparam int SG16 = 4;
  localparam int SG20 = 5;
  localparam int SG24 = 6;
  localparam int SG28 = 7;

  // Supervisor level code that routes the external input
  localparam logic [3:0] SVS_EXT_LEVEL = 4'hF;

  // Serial drive slots: P2.4, P2.5, P3.0, P3.3, P3.1, P3.2
  localparam int NSER   = 6;
  localparam int SR_P24 = 0;
  localparam int SR_P25 = 1;
  localparam int SR_P30 = 2;
  localparam int SR_P33 = 3;
  localparam int SR_P31 = 4;
  localparam int SR_P32 = 5;

  // Dedicated segment pins: segment number and group enable bit
  localparam int NDSEG = 12;
  localparam int DSEG_NUM [NDSEG] = '{12, 13, 14, 15, 16, 17, 18, 19, 22, 23, 24, 25};
  localparam int DSEG_GRP [NDSEG] = '{SG12, SG12, SG12, SG12, SG16, SG16, SG16, SG16,
                                      SG20, SG20, SG24, SG24};

  // Pin bit positions and the segments they carry
  localparam int B_CMP = 6;
  localparam int B_VSS = 7;
  localparam int S_P26 = 2;
  localparam int S_P27 = 3;
  localparam int S_P31 = 26;
  localparam int S_P32 = 27;
  localparam int S_P3H = 28;
  localparam int S_P5L = 20;
  localparam int B_LREF = 6;
  localparam int B_SVS  = 7;

  typedef struct packed {
    logic out;
    logic oe;
  } ppfm_drv_t;

  typedef struct packed {
    ppfm_byte_t out;
    ppfm_byte_t oe;
  } ppfm_pad_t;

endpackage

// *** hdl/ppfm_top.sv ***
// Pin function multiplexer for ports 2..6, dedicated segment pins,
// the common-zero pin and the shared test-data pin.
// Assumes peripherals run on i_clk_sys; pad inputs are asynchronous.
//
// Contract
// - Select and segment off gives plain I/O
// - P2.4/P2.5 carry serial A, unit drives direction
// - P2.6 comparator out, P2.7 drives ground
// - P3.0/P3.3 carry serial clocks and enables
// - P3.1/P3.2 serial B, or segments 26/27
// - Two-wire mode only pulls low
// - Group 28 makes P3.4..7 segments 28..31
// - Groups 8/4 make P4 segments 11..4
// - Group 20 makes P5.0/P5.1 segments 20/21
// - P5.2..7 commons, bias and reference
// - P6.0/P6.3 converter plus and amplifier outputs
// - P6.1/P6.4 converter minus and feedback
// - P6.2/P6.5/P6.6 amplifier inputs
// - P6.7 amplifier input or supervisor input
// - Dedicated segments drive or float by group
// - Common-zero pin always carries common zero
// - Test-data pin is input while programming
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps

module ppfm_top
  import ppfm_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  // Register port
  input  wire ppfm_addr_t               i_addr,
  input  wire ppfm_byte_t               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output ppfm_byte_t                    o_rdata,
  // Port pads
  input  wire ppfm_byte_t [NPORT-1:0]   i_pad_in,
  output ppfm_pad_t  [NPORT-1:0]        o_pad,
  // Serial units
  input  wire ppfm_drv_t [NSER-1:0]     i_serial_drv,
  input  wire logic                     i_serial_twowire,
  output logic [NSER-1:0]               o_serial_pin_in,
  // Comparator, LCD and supervisor
  input  wire logic                     i_comparator_result_out,
  input  wire logic [31:0]              i_segment_level,
  input  wire logic [3:0]               i_lcd_common_level,
  input  wire logic                     i_lcd_ref_select,
  input  wire logic [3:0]               i_supervisor_level_field,
  // Analog routing and dedicated LCD pins
  output ppfm_byte_t                    o_p5_analog_en,
  output ppfm_byte_t                    o_p6_analog_en,
  output logic                          o_lcd_external_reference_en,
  output logic                          o_supervisor_external_input_en,
  output logic [NDSEG-1:0]              o_seg_pin_out,
  output logic [NDSEG-1:0]              o_seg_pin_oe,
  output logic                          o_lcd_common_line_zero,
  // Shared test-data pin
  input  wire logic                     i_prog_active,
  input  wire logic                     i_tdo_data,
  input  wire logic                     i_tdo_oe,
  input  wire logic                     i_tdo_pad,
  output logic                          o_tdo_out,
  output logic                          o_tdo_oe,
  output logic                          o_test_data_in
);

  ppfm_byte_t [NPORT-1:0] dir_ff;
  ppfm_byte_t [NPORT-1:0] sel_ff;
  ppfm_byte_t [NPORT-1:0] out_ff;
  ppfm_byte_t [NPORT-1:0] pin_s1_ff;
  ppfm_byte_t [NPORT-1:0] pin_s2_ff;
  ppfm_byte_t             segen_ff;
  ppfm_byte_t             rdata_ff;
  ppfm_byte_t             nxt_rdata;
  ppfm_pad_t [NPORT-1:0]  pad_ff;
  ppfm_pad_t [NPORT-1:0]  nxt_pad;
  ppfm_byte_t             p5an_ff;
  ppfm_byte_t             nxt_p5an;
  ppfm_byte_t             p6an_ff;
  ppfm_byte_t             nxt_p6an;
  logic                   lref_ff;
  logic                   svs_ff;
  logic [NDSEG-1:0]       dseg_out_ff;
  logic [NDSEG-1:0]       dseg_oe_ff;
  logic [NDSEG-1:0]       nxt_dseg_out;
  logic [NDSEG-1:0]       nxt_dseg_oe;
  logic                   lcd_common_line_zero_ff;
  logic                   tdo_out_ff;
  logic                   tdo_oe_ff;
  logic                   tdo_s1_ff;
  logic                   tdo_s2_ff;
  logic                   tdi_ff;

  // Per-port control registers and pad input synchronisers
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        dir_ff[p] <= RST_BYTE;
        sel_ff[p] <= RST_BYTE;
        out_ff[p] <= RST_BYTE;
      end else if (i_wr) begin
        if (i_addr == ADR_DIR[p]) dir_ff[p] <= i_wdata;
        if (i_addr == ADR_SEL[p]) sel_ff[p] <= i_wdata;
        if (i_addr == ADR_OUT[p]) out_ff[p] <= i_wdata;
      end
    end

    // Second stage alone feeds logic; the first may be metastable
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        pin_s1_ff[p] <= RST_BYTE;
        pin_s2_ff[p] <= RST_BYTE;
      end else begin
        pin_s1_ff[p] <= i_pad_in[p];
        pin_s2_ff[p] <= pin_s1_ff[p];
      end
    end
  end

  // Segment group enable register
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      segen_ff <= RST_BYTE;
    end else if (i_wr && i_addr == ADR_SEGEN) begin
      segen_ff <= i_wdata;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    nxt_rdata = RST_BYTE;
    for (int p = 0; p < NPORT; p++) begin
      if (i_addr == ADR_IN[p])  nxt_rdata = pin_s2_ff[p];
      if (i_addr == ADR_OUT[p]) nxt_rdata = out_ff[p];
      if (i_addr == ADR_DIR[p]) nxt_rdata = dir_ff[p];
      if (i_addr == ADR_SEL[p]) nxt_rdata = sel_ff[p];
    end
    if (i_addr == ADR_SEGEN) nxt_rdata = segen_ff;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_ff <= RST_BYTE;
    end else begin
      rdata_ff <= i_rd ? nxt_rdata : RST_BYTE;
    end
  end

  // Pad ownership; later assignments take priority over earlier ones
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      nxt_pad[p].out = out_ff[p];
      nxt_pad[p].oe  = dir_ff[p];
    end
    nxt_p5an = RST_BYTE;
    nxt_p6an = RST_BYTE;
    // Serial A data pins on port 2
    for (int b = 4; b < 6; b++) begin
      if (sel_ff[P2][b]) begin
        nxt_pad[P2].out[b] = i_serial_drv[(b == 4) ? SR_P24 : SR_P25].out;
        nxt_pad[P2].oe[b]  = i_serial_drv[(b == 4) ? SR_P24 : SR_P25].oe;
      end
    end
    // Comparator and ground drive need select and output direction
    if (sel_ff[P2][B_CMP]) begin
      nxt_pad[P2].out[B_CMP] = i_comparator_result_out;
      nxt_pad[P2].oe[B_CMP]  = dir_ff[P2][B_CMP];
    end
    if (sel_ff[P2][B_VSS]) begin
      nxt_pad[P2].out[B_VSS] = 1'b0;
      nxt_pad[P2].oe[B_VSS]  = dir_ff[P2][B_VSS];
    end
    if (segen_ff[SG0]) begin
      nxt_pad[P2].out[B_CMP] = i_segment_level[S_P26];
      nxt_pad[P2].out[B_VSS] = i_segment_level[S_P27];
      nxt_pad[P2].oe[B_CMP]  = 1'b1;
      nxt_pad[P2].oe[B_VSS]  = 1'b1;
    end
    // Serial clock and enable pins on port 3
    if (sel_ff[P3][0]) begin
      nxt_pad[P3].out[0] = i_serial_drv[SR_P30].out;
      nxt_pad[P3].oe[0]  = i_serial_drv[SR_P30].oe;
    end
    if (sel_ff[P3][3]) begin
      nxt_pad[P3].out[3] = i_serial_drv[SR_P33].out;
      nxt_pad[P3].oe[3]  = i_serial_drv[SR_P33].oe;
    end
    // Serial B data lines; two-wire mode may only sink current
    for (int b = 1; b < 3; b++) begin
      if (sel_ff[P3][b]) begin
        nxt_pad[P3].out[b] = i_serial_drv[(b == 1) ? SR_P31 : SR_P32].out;
        nxt_pad[P3].oe[b]  = i_serial_drv[(b == 1) ? SR_P31 : SR_P32].oe;
        if (i_serial_twowire) begin
          nxt_pad[P3].out[b] = 1'b0;
          nxt_pad[P3].oe[b]  = i_serial_drv[(b == 1) ? SR_P31 : SR_P32].oe
                               & ~i_serial_drv[(b == 1) ? SR_P31 : SR_P32].out;
        end
      end
    end
    if (segen_ff[SG24]) begin
      nxt_pad[P3].out[1] = i_segment_level[S_P31];
      nxt_pad[P3].out[2] = i_segment_level[S_P32];
      nxt_pad[P3].oe[1]  = 1'b1;
      nxt_pad[P3].oe[2]  = 1'b1;
    end
    // Segment groups on the upper port 3 and port 4 pins
    for (int b = 4; b < PW; b++) begin
      if (segen_ff[SG28]) begin
        nxt_pad[P3].out[b] = i_segment_level[S_P3H + b - 4];
        nxt_pad[P3].oe[b]  = 1'b1;
      end
      if (segen_ff[SG4]) begin
        nxt_pad[P4].out[b] = i_segment_level[11 - b];
        nxt_pad[P4].oe[b]  = 1'b1;
      end
      if (segen_ff[SG8]) begin
        nxt_pad[P4].out[b-4] = i_segment_level[15 - b];
        nxt_pad[P4].oe[b-4]  = 1'b1;
      end
    end
    // Port 5: segments, commons and bias pins
    if (segen_ff[SG20]) begin
      nxt_pad[P5].out[1:0] = i_segment_level[S_P5L +: 2];
      nxt_pad[P5].oe[1:0]  = 2'h3;
    end
    for (int b = 2; b < 5; b++) begin
      if (sel_ff[P5][b]) begin
        nxt_pad[P5].out[b] = i_lcd_common_level[b - 1];
        nxt_pad[P5].oe[b]  = 1'b1;
      end
    end
    for (int b = 5; b < PW; b++) begin
      if (sel_ff[P5][b]) begin
        nxt_pad[P5].out[b] = 1'b0;
        nxt_pad[P5].oe[b]  = 1'b0;
        nxt_p5an[b]        = 1'b1;
      end
    end
    // Port 6: every selected pin goes analog, direction ignored
    for (int b = 0; b < PW; b++) begin
      if (sel_ff[P6][b]) begin
        nxt_pad[P6].out[b] = 1'b0;
        nxt_pad[P6].oe[b]  = 1'b0;
        nxt_p6an[b]        = 1'b1;
      end
    end
  end

  // Dedicated segment pins float when their group is off
  always_comb begin
    for (int k = 0; k < NDSEG; k++) begin
      nxt_dseg_oe[k]  = segen_ff[DSEG_GRP[k]];
      nxt_dseg_out[k] = segen_ff[DSEG_GRP[k]] & i_segment_level[DSEG_NUM[k]];
    end
  end

  // Registered pad and analog controls: one cycle from any change
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pad_ff      <= '0;
      p5an_ff     <= RST_BYTE;
      p6an_ff     <= RST_BYTE;
      lref_ff     <= 1'b0;
      svs_ff      <= 1'b0;
      dseg_out_ff <= '0;
      dseg_oe_ff  <= '0;
      lcd_common_line_zero_ff     <= 1'b0;
    end else begin
      pad_ff      <= nxt_pad;
      p5an_ff     <= nxt_p5an;
      p6an_ff     <= nxt_p6an;
      lref_ff     <= sel_ff[P5][B_LREF] & i_lcd_ref_select;
      svs_ff      <= sel_ff[P6][B_SVS] && i_supervisor_level_field == SVS_EXT_LEVEL;
      dseg_out_ff <= nxt_dseg_out;
      dseg_oe_ff  <= nxt_dseg_oe;
      lcd_common_line_zero_ff     <= i_lcd_common_level[0];
    end
  end

  // Test-data pin turns round to an input while programming
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tdo_out_ff <= 1'b0;
      tdo_oe_ff  <= 1'b0;
      tdo_s1_ff  <= 1'b0;
      tdo_s2_ff  <= 1'b0;
      tdi_ff     <= 1'b0;
    end else begin
      tdo_out_ff <= i_tdo_data & ~i_prog_active;
      tdo_oe_ff  <= i_tdo_oe & ~i_prog_active;
      tdo_s1_ff  <= i_tdo_pad;
      tdo_s2_ff  <= tdo_s1_ff;
      tdi_ff     <= tdo_s2_ff & i_prog_active;
    end
  end

  // Outputs straight from flops
  assign o_rdata                        = rdata_ff;
  assign o_pad                          = pad_ff;
  assign o_p5_analog_en                 = p5an_ff;
  assign o_p6_analog_en                 = p6an_ff;
  assign o_lcd_external_reference_en    = lref_ff;
  assign o_supervisor_external_input_en = svs_ff;
  assign o_seg_pin_out                  = dseg_out_ff;
  assign o_seg_pin_oe                   = dseg_oe_ff;
  assign o_lcd_common_line_zero         = lcd_common_line_zero_ff;
  assign o_tdo_out                      = tdo_out_ff;
  assign o_tdo_oe                       = tdo_oe_ff;
  assign o_test_data_in                 = tdi_ff;
  assign o_serial_pin_in = {pin_s2_ff[P3][2], pin_s2_ff[P3][1], pin_s2_ff[P3][3],
                            pin_s2_ff[P3][0], pin_s2_ff[P2][5], pin_s2_ff[P2][4]};

  // Checks: pad state one cycle after its cause
  property p_gpio;
    @(posedge i_clk_sys) disable iff (i_reset)
    !sel_ff[P4][4] && !segen_ff[SG4] |=> o_pad[P4].oe[4] == $past(dir_ff[P4][4]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio direction not followed");
  property p_ser_a;
    @(posedge i_clk_sys) disable iff (i_reset)
    sel_ff[P2][4] |=> o_pad[P2].oe[4] == $past(i_serial_drv[SR_P24].oe)
                      && o_pad[P2].out[4] == $past(i_serial_drv[SR_P24].out);
  endproperty
  a_ser_a: assert property (p_ser_a) else $error("serial A pad not owned");
  property p_cmp;
    @(posedge i_clk_sys) disable iff (i_reset)
    sel_ff[P2][B_CMP] && dir_ff[P2][B_CMP] && !segen_ff[SG0]
      |=> o_pad[P2].oe[B_CMP] && o_pad[P2].out[B_CMP] == $past(i_comparator_result_out);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator not on pin");
  property p_seg0;
    @(posedge i_clk_sys) disable iff (i_reset)
    segen_ff[SG0] |=> o_pad[P2].oe[B_VSS] && o_pad[P2].out[B_VSS] == $past(i_segment_level[S_P27]);
  endproperty
  a_seg0: assert property (p_seg0) else $error("group 0 segment missing");
  property p_twowire;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_serial_twowire && sel_ff[P3][1] && !segen_ff[SG24] |=> !(o_pad[P3].oe[1] && o_pad[P3].out[1]);
  endproperty
  a_twowire: assert property (p_twowire) else $error("two-wire pin driven high");
  property p_seg28;
    @(posedge i_clk_sys) disable iff (i_reset)
    segen_ff[SG28] |=> o_pad[P3].oe[7:4] == 4'hF && o_pad[P3].out[7:4] == $past(i_segment_level[31:28]);
  endproperty
  a_seg28: assert property (p_seg28) else $error("group 28 segments wrong");
  property p_seg8;
    @(posedge i_clk_sys) disable iff (i_reset)
    segen_ff[SG8] |=> o_pad[P4].out[0] == $past(i_segment_level[11]) && o_pad[P4].oe[0];
  endproperty
  a_seg8: assert property (p_seg8) else $error("group 8 order wrong");
  property p_analog;
    @(posedge i_clk_sys) disable iff (i_reset)
    sel_ff[P6][0] && dir_ff[P6][0] |=> !o_pad[P6].oe[0] && o_p6_analog_en[0];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin still digital");
  property p_dseg;
    @(posedge i_clk_sys) disable iff (i_reset)
    !segen_ff[SG12] ##1 !segen_ff[SG12] |-> o_seg_pin_oe[3:0] == 4'h0;
  endproperty
  a_dseg: assert property (p_dseg) else $error("disabled segment pin driven");
  property p_prog;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_prog_active |=> !o_tdo_oe ##2 (o_test_data_in == ($past(i_tdo_pad, 3) && $past(i_prog_active)));
  endproperty
  a_prog: assert property (p_prog) else $error("test pin not turned to input");

endmodule

// *** bench/ppfm_pad_model.sv ***
// Pad model: external circuits on the port pins.
// Assumes pads resolve within the cycle; design drive wins over the board.
`timescale 1ns/1ps

module ppfm_pad_model
  import ppfm_pkg::*;
(
  // Clock
  input  wire logic                   i_clk_sys,
  // Design pad drive
  input  wire ppfm_pad_t [NPORT-1:0]  i_pad,
  // Board drive commanded by the bench
  input  wire ppfm_byte_t             i_ext_val,
  input  wire ppfm_byte_t             i_ext_en,
  // Resolved pin levels
  output ppfm_byte_t [NPORT-1:0]      o_level
);
  ppfm_byte_t flip_ff = 8'h55;

  // Undriven pins wander, so a stale level never passes for a read
  always_ff @(posedge i_clk_sys) begin
    flip_ff <= ~flip_ff;
  end

  // Resolve each pin from design, board or floating
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      o_level[p] = (i_pad[p].oe & i_pad[p].out) | (~i_pad[p].oe & i_ext_en & i_ext_val)
                 | (~i_pad[p].oe & ~i_ext_en & flip_ff);
    end
  end
endmodule

// *** bench/ppfm_top_test.sv ***
// Self-checking bench for the pin function multiplexer.
// Assumes the register map and pin tables of ppfm_pkg.
`timescale 1ns/1ps

module ppfm_top_test;
  import ppfm_pkg::*;

  logic                    clk_sys = 1'b0;
  logic                    reset   = 1'b1;
  ppfm_addr_t              addr    = '0;
  ppfm_byte_t              wdata   = '0;
  logic                    wr      = 1'b0;
  logic                    rd      = 1'b0;
  ppfm_drv_t [NSER-1:0]    ser     = '0;
  logic                    twowire = 1'b0;
  logic                    cmp     = 1'b0;
  logic [31:0]             seg     = 32'hC3A5_5A3C;
  logic [3:0]              com     = 4'h9;
  logic                    lref    = 1'b0;
  logic [3:0]              svs     = 4'h0;
  logic                    prog    = 1'b0;
  logic                    tdo_d   = 1'b0;
  logic                    tdo_e   = 1'b0;
  logic                    tdo_pad = 1'b0;
  ppfm_byte_t              ext_val = 8'h3C;
  ppfm_byte_t              ext_en  = 8'hFF;
  ppfm_byte_t              rdata;
  ppfm_byte_t [NPORT-1:0]  pad_in;
  ppfm_pad_t [NPORT-1:0]   pad;
  logic [NSER-1:0]         ser_in;
  ppfm_byte_t              p5an;
  ppfm_byte_t              p6an;
  logic                    lref_en;
  logic                    svs_en;
  logic [NDSEG-1:0]        dseg_out;
  logic [NDSEG-1:0]        dseg_oe;
  logic                    lcd_common_line_zero;
  logic                    tdo_out;
  logic                    tdo_oe;
  logic                    tdi;
  int                      error_cnt = 0;
  int                      n_checks  = 0;
  int                      cyc       = 0;
  int                      sp [NSER] = '{P2, P2, P3, P3, P3, P3};
  int                      sb [NSER] = '{4, 5, 0, 3, 1, 2};
  ppfm_byte_t              e;
  ppfm_byte_t              mo;
  logic                    so;
  logic                    sv;

  always #50 clk_sys = ~clk_sys;

  ppfm_top i_ppfm_top (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pad_in(pad_in), .o_pad(pad), .i_serial_drv(ser), .i_serial_twowire(twowire),
    .o_serial_pin_in(ser_in), .i_comparator_result_out(cmp), .i_segment_level(seg),
    .i_lcd_common_level(com), .i_lcd_ref_select(lref), .i_supervisor_level_field(svs),
    .o_p5_analog_en(p5an), .o_p6_analog_en(p6an), .o_lcd_external_reference_en(lref_en),
    .o_supervisor_external_input_en(svs_en), .o_seg_pin_out(dseg_out), .o_seg_pin_oe(dseg_oe),
    .o_lcd_common_line_zero(lcd_common_line_zero), .i_prog_active(prog), .i_tdo_data(tdo_d), .i_tdo_oe(tdo_e),
    .i_tdo_pad(tdo_pad), .o_tdo_out(tdo_out), .o_tdo_oe(tdo_oe), .o_test_data_in(tdi));

  ppfm_pad_model i_ppfm_pad_model (
    .i_clk_sys(clk_sys), .i_pad(pad), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pad_in));

  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input ppfm_addr_t a, input ppfm_byte_t d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input ppfm_addr_t a, input ppfm_byte_t x);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    chk("rdata", rdata, x);
    @(negedge clk_sys);
    chk("rdata_idle", rdata, 8'h00);
  endtask

  // Covers the three-edge synchroniser path with margin
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset state and unmapped place
    for (int p = 0; p < NPORT; p++) begin
      rd_chk(ADR_DIR[p], RST_BYTE);
      rd_chk(ADR_SEL[p], RST_BYTE);
      chk("oe_rst", pad[p].oe, 8'h00);
    end
    wr_reg(9'h0FF, 8'hFF);
    rd_chk(9'h0FF, 8'h00);
    rd_chk(ADR_SEGEN, RST_BYTE);
    $display("test reset done");
    // Plain I/O on every port, input register read-only
    for (int p = 0; p < NPORT; p++) begin
      wr_reg(ADR_OUT[p], 8'hA5);
      wr_reg(ADR_DIR[p], 8'h0F);
    end
    settle();
    for (int p = 0; p < NPORT; p++) begin
      chk("gpio_oe", pad[p].oe, 8'h0F);
      chk("gpio_out", pad[p].out & 8'h0F, 8'h05);
      wr_reg(ADR_IN[p], 8'hFF);
      rd_chk(ADR_IN[p], 8'h35);
      rd_chk(ADR_OUT[p], 8'hA5);
      rd_chk(ADR_DIR[p], 8'h0F);
    end
    $display("test gpio done");
    // Serial units own direction, direction bits disagree on purpose
    wr_reg(ADR_SEL[P2], 8'h30);
    wr_reg(ADR_SEL[P3], 8'h0F);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      ser     <= k[0] ? 12'h863 : 12'h79C;
      twowire <= k[1];
      settle();
      for (int s = 0; s < NSER; s++) begin
        so = ser[s].oe;
        sv = ser[s].out;
        if (k[1] && s >= SR_P31) begin
          so = so & ~sv;
          sv = 1'b0;
        end
        chk("ser_oe", pad[sp[s]].oe[sb[s]], so);
        chk("ser_out", pad[sp[s]].out[sb[s]] & so, sv & so);
        chk("ser_in", ser_in[s], so ? sv : ext_val[sb[s]]);
      end
    end
    @(posedge clk_sys);
    twowire <= 1'b0;
    $display("test serial done");
    // Comparator and ground drive on the upper port 2 pins
    wr_reg(ADR_SEL[P2], 8'hC0);
    wr_reg(ADR_DIR[P2], 8'hC0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      cmp <= k[0];
      settle();
      chk("cmp_oe", pad[P2].oe[7:6], 2'b11);
      chk("cmp_out", pad[P2].out[7:6], {1'b0, k[0]});
    end
    $display("test comparator done");
    // Walk each segment group; select and direction set only on P2.6/P2.7, where group 0 must win
    for (int p = 0; p < NPORT; p++) begin
      wr_reg(ADR_DIR[p], 8'h00);
    end
    wr_reg(ADR_DIR[P2], 8'hC0);
    wr_reg(ADR_SEL[P3], 8'h00);
    ext_en <= 8'h00;
    for (int g = 0; g < 9; g++) begin
      e = (g < 8) ? (8'h01 << g) : 8'h00;
      wr_reg(ADR_SEGEN, e);
      rd_chk(ADR_SEGEN, e);
      settle();
      mo = {{4{e[SG28]}}, 1'b0, {2{e[SG24]}}, 1'b0};
      chk("p3_oe", pad[P3].oe, mo);
      chk("p3_out", pad[P3].out & mo, {seg[31:28], 1'b0, seg[27:26], 1'b0} & mo);
      mo = {{4{e[SG4]}}, {4{e[SG8]}}};
      chk("p4_oe", pad[P4].oe, mo);
      chk("p4_out", pad[P4].out & mo, {seg[4], seg[5], seg[6], seg[7], seg[8], seg[9], seg[10], seg[11]} & mo);
      chk("p5_oe", pad[P5].oe[1:0], {2{e[SG20]}});
      chk("p5_out", pad[P5].out[1:0] & {2{e[SG20]}}, seg[21:20] & {2{e[SG20]}});
      chk("p2_out", pad[P2].out[7:6], e[SG0] ? seg[3:2] : {1'b0, cmp});
      chk("p2_oe", pad[P2].oe[7:6], 2'b11);
      for (int i = 0; i < NDSEG; i++) begin
        chk("dseg_oe", dseg_oe[i], e[DSEG_GRP[i]]);
        chk("dseg_out", dseg_out[i], e[DSEG_GRP[i]] & seg[DSEG_NUM[i]]);
      end
    end
    $display("test segments done");
    // Commons, bias, reference, converter, amplifiers, supervisor
    wr_reg(ADR_DIR[P5], 8'hFF);
    wr_reg(ADR_SEL[P5], 8'hFC);
    wr_reg(ADR_DIR[P6], 8'hFF);
    wr_reg(ADR_SEL[P6], 8'hFF);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      lref <= ~k[0];
      svs  <= k[0] ? 4'hE : SVS_EXT_LEVEL;
      com  <= k[0] ? 4'h6 : 4'h9;
      settle();
      chk("p5_oe", pad[P5].oe, 8'h1F);
      chk("p5_com", pad[P5].out[4:2], com[3:1]);
      chk("p5_an", p5an & 8'hE0, 8'hE0);
      chk("lref", lref_en, !k[0]);
      chk("p6_oe", pad[P6].oe, 8'h00);
      chk("p6_an", p6an, 8'hFF);
      chk("svs", svs_en, !k[0]);
      chk("lcd_common_line_zero", lcd_common_line_zero, com[0]);
    end
    wr_reg(ADR_SEL[P6], 8'h00);
    settle();
    chk("p6_gpio_oe", pad[P6].oe, 8'hFF);
    chk("p6_gpio_an", p6an, 8'h00);
    $display("test analog done");
    // Shared test-data pin, normal then programming
    @(posedge clk_sys);
    tdo_e   <= 1'b1;
    tdo_d   <= 1'b1;
    tdo_pad <= 1'b1;
    settle();
    chk("tdo_oe", tdo_oe, 1'b1);
    chk("tdo_out", tdo_out, 1'b1);
    chk("tdi_idle", tdi, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      prog    <= 1'b1;
      tdo_pad <= ~k[0];
      settle();
      chk("tdo_prog_oe", tdo_oe, 1'b0);
      chk("tdi_prog", tdi, !k[0]);
    end
    $display("test test_data done");
    close_out();
  end
endmodule
